// ---- pdmu_consts.vh ----
// Constants for the doorbell and message unit.
// Assumes inclusion by bare name from the design file.
`ifndef PDMU_CONSTS_VH
`define PDMU_CONSTS_VH
`define PDMU_WORD_W 32
`define PDMU_SEL_W 2
`define PDMU_SEL_DB 2'h0
`define PDMU_SEL_MSG0 2'h1
`define PDMU_SEL_MSG1 2'h2
`define PDMU_MSG_N 2
`define PDMU_ZERO_WORD 32'h00000000
`endif

// ---- pdmu_message_unit.v ----
// Doorbell and message mailbox between a PCI host side and the local core.
// Assumes both sides present single-cycle write/read/acknowledge strobes
// synchronous to clk; the host side is already in the clk domain.
// Interrupt outputs are plain levels; the interrupt controller downstream
// prioritises them and owns any masking.
//
// Overview of operation
// [R1] One 32-bit inbound doorbell, host writable.
// [R2] Host sets inbound bits; any set bit interrupts core.
// [R3] Outbound doorbell write leaving bits set asserts INTA.
// [R4] Only host clears outbound bits, writing ones.
// [R5] Two inbound, two outbound 32-bit message registers.
// [R6] Inbound message write stores and interrupts core.
// [R7] Core outbound message write asserts INTA.
// [R8] Outbound events external, inbound events to core.
// [R9] Queues live in memory, outside this block.
// [R10] Core clears inbound doorbell bits by writing ones.
// [R11] Message interrupts held until read or acknowledge.
`timescale 1ns/1ps
`default_nettype none
`include "pdmu_consts.vh"

module pdmu_message_unit #(
    parameter WORD_W = `PDMU_WORD_W
) (
    input wire clk,
    input wire rstn,
    input wire ce,
    // Host (PCI) side.
    input wire host_wr,
    input wire host_rd,
    input wire [`PDMU_SEL_W-1:0] host_sel,
    input wire [WORD_W-1:0] host_wdata,
    output reg [WORD_W-1:0] host_rdata,
    output wire inta_n,
    // Local core side.
    input wire core_wr,
    input wire core_rd,
    input wire core_ack,
    input wire [`PDMU_SEL_W-1:0] core_sel,
    input wire [WORD_W-1:0] core_wdata,
    output reg [WORD_W-1:0] core_rdata,
    output wire core_irq,
    output wire outbound_irq
);

    localparam MSG_N = `PDMU_MSG_N;

    reg rst_meta;
    reg rst_sync;
    reg [WORD_W-1:0] in_db; // [R1]
    reg [WORD_W-1:0] out_db; // [R3]
    reg [WORD_W-1:0] next_in_db;
    reg [WORD_W-1:0] next_out_db;
    reg [WORD_W-1:0] next_host_rdata;
    reg [WORD_W-1:0] next_core_rdata;
    wire [MSG_N*WORD_W-1:0] in_msg_all;
    wire [MSG_N*WORD_W-1:0] out_msg_all;
    wire [MSG_N-1:0] in_pend;
    wire [MSG_N-1:0] out_pend;
    wire [WORD_W-1:0] host_db_mask;
    wire [WORD_W-1:0] core_db_mask;
    wire host_db_wr;
    wire core_db_wr;
    wire any_in_db;
    wire any_out_db;

    assign host_db_wr = host_wr && (host_sel == `PDMU_SEL_DB);
    assign core_db_wr = core_wr && (core_sel == `PDMU_SEL_DB);

    // Ones in a doorbell write set bits on the far register and clear bits
    // on the near one; a zero word leaves both untouched.
    assign host_db_mask = host_db_wr ? host_wdata : `PDMU_ZERO_WORD;
    assign core_db_mask = core_db_wr ? core_wdata : `PDMU_ZERO_WORD;

    // Reset is applied at once but released through two flops, so every
    // register leaves reset on the same clean edge.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Set wins over clear: a bit rung by one side in the very cycle the
    // other side clears it stays set, so no doorbell is silently lost.
    always @*
    begin
        next_in_db = (in_db & ~core_db_mask) | host_db_mask; // [R2] [R10]
        next_out_db = (out_db & ~host_db_mask) | core_db_mask; // [R4]
    end

    always @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            in_db <= `PDMU_ZERO_WORD;
            out_db <= `PDMU_ZERO_WORD;
        end
        else if (ce)
        begin
            in_db <= next_in_db; // [R2]
            out_db <= next_out_db; // [R3]
        end
    end

    // Only the register end of each mailbox lives here; the queues that
    // feed it stay in local memory and are moved by the core.
    genvar i; // [R9]
    generate
        for (i = 0; i < MSG_N; i = i + 1)
        begin : msg_g
            localparam [`PDMU_SEL_W-1:0] SEL_CODE =
                (i == 0) ? `PDMU_SEL_MSG0 : `PDMU_SEL_MSG1;
            reg [WORD_W-1:0] in_word;
            reg [WORD_W-1:0] out_word;
            reg in_flag;
            reg out_flag;
            wire host_load = host_wr && (host_sel == SEL_CODE);
            wire core_load = core_wr && (core_sel == SEL_CODE);
            wire host_take = host_rd && (host_sel == SEL_CODE);
            wire core_take = core_ack && (core_sel == SEL_CODE);

            always @(posedge clk or negedge rst_sync)
            begin
                if (!rst_sync)
                begin
                    in_word <= `PDMU_ZERO_WORD;
                    out_word <= `PDMU_ZERO_WORD;
                    in_flag <= 1'b0;
                    out_flag <= 1'b0;
                end
                else if (ce)
                begin
                    if (host_load)
                    begin
                        in_word <= host_wdata; // [R5] [R6]
                    end
                    if (core_load)
                    begin
                        out_word <= core_wdata; // [R5] [R7]
                    end
                    // A fresh message beats an acknowledge of the old one.
                    in_flag <= host_load | (in_flag & ~core_take); // [R11]
                    out_flag <= core_load | (out_flag & ~host_take); // [R11]
                end
            end

            assign in_msg_all[i*WORD_W +: WORD_W] = in_word;
            assign out_msg_all[i*WORD_W +: WORD_W] = out_word;
            assign in_pend[i] = in_flag; // [R6]
            assign out_pend[i] = out_flag; // [R7]
        end
    endgenerate

    // The host reads what the core writes; the unmapped selector reads as
    // zero so a stray read never returns stale data.
    always @*
    begin
        case (host_sel)
            `PDMU_SEL_DB: next_host_rdata = out_db;
            `PDMU_SEL_MSG0: next_host_rdata = out_msg_all[WORD_W-1:0];
            `PDMU_SEL_MSG1: next_host_rdata = out_msg_all[2*WORD_W-1:WORD_W];
            default: next_host_rdata = `PDMU_ZERO_WORD;
        endcase
    end

    // The core reads the inbound side, which the host writes.
    always @*
    begin
        case (core_sel)
            `PDMU_SEL_DB: next_core_rdata = in_db;
            `PDMU_SEL_MSG0: next_core_rdata = in_msg_all[WORD_W-1:0];
            `PDMU_SEL_MSG1: next_core_rdata = in_msg_all[2*WORD_W-1:WORD_W];
            default: next_core_rdata = `PDMU_ZERO_WORD;
        endcase
    end

    // Read data is registered and held until the next read on that side.
    always @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            host_rdata <= `PDMU_ZERO_WORD;
        end
        else if (ce && host_rd)
        begin
            host_rdata <= next_host_rdata; // [R5]
        end
    end

    always @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            core_rdata <= `PDMU_ZERO_WORD;
        end
        else if (ce && core_rd)
        begin
            core_rdata <= next_core_rdata; // [R5]
        end
    end

    assign any_in_db = |in_db;
    assign any_out_db = |out_db;

    // Outbound events leave as the external request toward the host and
    // inbound ones as the internal request to the core; the interrupt
    // controller downstream does any prioritising.
    assign outbound_irq = any_out_db | (|out_pend); // [R8]
    assign inta_n = ~outbound_irq; // [R3] [R7]
    assign core_irq = any_in_db | (|in_pend); // [R2] [R6] [R8]

endmodule // pdmu_message_unit

`default_nettype wire

// ---- pdmu_properties.sv ----
// Port checker for the message unit, bound after the module.
// Assumes one clock; strobes count only with ce high.
`timescale 1ns/1ps
`default_nettype none
module pdmu_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic core_wr,
    input wire logic core_ack,
    input wire logic [1:0] host_sel,
    input wire logic [1:0] core_sel,
    input wire logic [31:0] host_wdata,
    input wire logic [31:0] core_wdata,
    input wire logic [31:0] host_rdata,
    input wire logic inta_n,
    input wire logic core_irq,
    input wire logic outbound_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire hw = ce && host_wr;
    wire cw = ce && core_wr;
    property p_dbi; hw && host_sel == 2'h0 && |host_wdata |=> core_irq;
    endproperty
    a_dbi: assert property (p_dbi) else $error("dbi");
    property p_dbo; cw && core_sel == 2'h0 && |core_wdata |=> !inta_n;
    endproperty
    a_dbo: assert property (p_dbo) else $error("dbo");
    property p_mi; hw && ^host_sel |=> core_irq; endproperty
    a_mi: assert property (p_mi) else $error("mi");
    property p_mo; cw && ^core_sel |=> !inta_n; endproperty
    a_mo: assert property (p_mo) else $error("mo");
    property p_rt; outbound_irq ^ inta_n; endproperty
    a_rt: assert property (p_rt) else $error("rt");
    property p_ih; !inta_n && !(ce && (host_wr || host_rd)) |=> !inta_n;
    endproperty
    a_ih: assert property (p_ih) else $error("ih");
    property p_qh; core_irq && !(ce && (core_wr || core_ack)) |=> core_irq;
    endproperty
    a_qh: assert property (p_qh) else $error("qh");
    property p_ur; ce && host_rd && host_sel == 2'h3 |=> host_rdata == 0;
    endproperty
    a_ur: assert property (p_ur) else $error("ur");
    property p_ce; !ce |=> $stable(host_rdata) && $stable(inta_n)
        && $stable(core_irq); endproperty
    a_ce: assert property (p_ce) else $error("ce");
endmodule // pdmu_checker
bind pdmu_message_unit pdmu_checker pdmu_checker_i (.*);
`default_nettype wire

// ---- pdmu_host_model.sv ----
// Host stand-in driving the PCI side of the message unit.
// Assumes the shared clk; released data is inverted, never held.
`timescale 1ns/1ps
`default_nettype none
module pdmu_host_model (
    input wire logic clk,
    output logic wr = 1'h0,
    output logic rd = 1'h0,
    output logic [1:0] sel = 2'h0,
    output logic [31:0] wdata = 32'h0
);
    task put(input logic [1:0] s, input logic [31:0] d, input logic r);
        @(posedge clk);
        {wr, rd, sel, wdata} <= {!r, r, s, d};
        @(posedge clk);
        {wr, rd, wdata} <= {2'h0, ~d};
        @(negedge clk);
    endtask
endmodule // pdmu_host_model
`default_nettype wire

// ---- pdmu_message_unit_bench.sv ----
// Bench for the message unit with the host stand-in on the PCI side.
// Assumes ce high save in the freeze test; results are read at falling edges.
`timescale 1ns/1ps
`default_nettype none
module pdmu_message_unit_bench;
    logic clk = 1'h0, rstn = 1'h0, cw = 1'h0, cr = 1'h0, ca = 1'h0;
    logic ce = 1'h1;
    logic [1:0] cs = 2'h0, hs;
    logic [31:0] cd = 32'h0, hq, cq, hd;
    logic hw, hr, ii, ci, oi;
    int miscompares = 0, total_checks = 0;
    always #50 clk = ~clk;
    pdmu_host_model pdmu_host_model_i (.clk(clk), .wr(hw), .rd(hr),
        .sel(hs), .wdata(hd));
    pdmu_message_unit pdmu_message_unit_i (.clk(clk), .rstn(rstn),
        .ce(ce), .host_wr(hw), .host_rd(hr), .host_sel(hs),
        .host_wdata(hd), .host_rdata(hq), .inta_n(ii), .core_wr(cw),
        .core_rd(cr), .core_ack(ca), .core_sel(cs), .core_wdata(cd),
        .core_rdata(cq), .core_irq(ci), .outbound_irq(oi));
    task chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask
    // The k argument packs write, read and acknowledge strobes.
    task core(input logic [1:0] s, input logic [31:0] d, input logic [2:0] k);
        @(posedge clk);
        {cw, cr, ca, cs, cd} <= {k, s, d};
        @(posedge clk);
        {cw, cr, ca, cd} <= {3'h0, ~d};
        @(negedge clk);
    endtask
    task t_msg;
        pdmu_host_model_i.put(2'h1, 32'h12345678, 1'h0);
        chk("irq", ci, 1);
        core(2'h1, 0, 3'h2);
        chk("crd", cq, 32'h12345678);
        core(2'h1, 0, 3'h1);
        chk("irq", ci, 0);
        core(2'h2, 32'h0badf00d, 3'h4);
        chk("inta", ii, 0);
        pdmu_host_model_i.put(2'h2, 0, 1'h1);
        chk("hrd", hq, 32'h0badf00d);
        chk("inta", ii, 1);
        pdmu_host_model_i.put(2'h3, 0, 1'h1);
        chk("hole", hq, 0);
        $display("test msg done");
    endtask
    task t_door;
        core(2'h0, 32'h80000001, 3'h4);
        chk("oirq", oi, 1);
        pdmu_host_model_i.put(2'h0, 32'h1, 1'h0);
        chk("inta", ii, 0);
        chk("irq", ci, 1);
        pdmu_host_model_i.put(2'h0, 32'h80000000, 1'h0);
        chk("inta", ii, 1);
        core(2'h0, 32'h80000001, 3'h4);
        chk("irq", ci, 0);
        $display("test door done");
    endtask
    // Doorbell read-back, same-cycle set against clear, and the message
    // registers that the first test leaves alone.
    task t_more;
        pdmu_host_model_i.put(2'h0, 0, 1'h1);
        chk("hdb", hq, 32'h80000001);
        pdmu_host_model_i.put(2'h0, 32'h80000001, 1'h0);
        chk("inta", ii, 1);
        core(2'h0, 0, 3'h2);
        chk("cdb", cq, 32'h80000001);
        fork
            pdmu_host_model_i.put(2'h0, 32'h10, 1'h0);
            core(2'h0, 32'h80000011, 3'h4);
        join
        core(2'h0, 0, 3'h2);
        chk("cdb", cq, 32'h10);
        pdmu_host_model_i.put(2'h0, 0, 1'h1);
        chk("hdb", hq, 32'h80000011);
        core(2'h0, 32'h10, 3'h4);
        chk("irq", ci, 0);
        pdmu_host_model_i.put(2'h2, 32'h0000cafe, 1'h0);
        chk("irq", ci, 1);
        core(2'h2, 0, 3'h2);
        chk("crd", cq, 32'h0000cafe);
        core(2'h2, 0, 3'h1);
        chk("irq", ci, 0);
        pdmu_host_model_i.put(2'h0, 32'h80000011, 1'h0);
        chk("inta", ii, 1);
        core(2'h1, 32'h5a5a0001, 3'h4);
        chk("inta", ii, 0);
        pdmu_host_model_i.put(2'h1, 0, 1'h1);
        chk("hrd", hq, 32'h5a5a0001);
        chk("inta", ii, 1);
        $display("test more done");
    endtask
    // With ce low a write and a read must both be ignored.
    task t_freeze;
        @(posedge clk);
        ce <= 1'h0;
        core(2'h1, 32'h00001111, 3'h4);
        chk("inta", ii, 1);
        pdmu_host_model_i.put(2'h2, 0, 1'h1);
        chk("hrd", hq, 32'h5a5a0001);
        @(posedge clk);
        ce <= 1'h1;
        pdmu_host_model_i.put(2'h1, 0, 1'h1);
        chk("hrd", hq, 32'h5a5a0001);
        chk("oirq", oi, 0);
        $display("test freeze done");
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        repeat (3) @(posedge clk);
        t_msg;
        t_door;
        t_more;
        t_freeze;
        test_done;
    end
endmodule // pdmu_message_unit_bench
`default_nettype wire
